//--- hw/pps_manager.sv
// Notes on behaviour
// - Lockout threshold 4.18..16 V, strap or host
// - Lockout strap resistor maps to threshold table
// - Input below lockout shuts down at once
// - Lockout shutdown blocks restart until cleared
// - Address strap decodes to bus address
// - Address strap also picks setpoint group
// - Overvoltage limit defaults 15% above target
// - Overvoltage shuts down, never retries
// - Output sampled for prebias before ramp
// - Low prebias: start from it, ramp up
// - Ramp is 256 steps of (ramp time cycles >> 8) cycles, at least one cycle each
// - High prebias: hold prebias level, drivers on
// - At ramp end move to target, power good only after settling
// - Prebias over limit: no start, overvoltage fault
// - Average overcurrent limit host programmable
// - Peak limit derived from input, frequency, setpoint
// - Overcurrent shuts down, retries after 70 ms
// - Temperature limit 115 C, compared continuously
// - Over-temperature shuts down, never retries
// - Power good within 10% window, polarity set
// - Power good only after 4 ms settled
`timescale 1ns/1ps
`include "pps_map.svh"

module pps_manager #(
  parameter int unsigned CYC_PER_MS   = `PPS_CYC_PER_MS,
  parameter int unsigned OC_RETRY_CYC = `PPS_OC_RETRY_CYC,
  parameter int unsigned PG_DELAY_CYC = `PPS_PG_DELAY_CYC,
  parameter int unsigned RIPPLE_GAIN  = 1
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire pps_pkg::pps_word_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output pps_pkg::pps_word_t     reg_rdata,
  input  wire logic              strap_valid,
  input  wire logic [4:0]        lockout_strap_code,
  input  wire logic [5:0]        address_strap_pin,
  input  wire logic [15:0]       vin_mv,
  input  wire logic [15:0]       sense_positive,
  input  wire logic [15:0]       iout_ma,
  input  wire logic [15:0]       ipeak_ma,
  input  wire logic [15:0]       temp_c,
  input  wire logic [15:0]       fsw_khz,
  output logic                   drivers_enable,
  output logic [15:0]            target_mv,
  output logic                   power_good_output,
  output logic [6:0]             bus_address,
  output logic                   setpoint_group_select
);
  import pps_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pps_state_t  st_ff;
  pps_word_t   ctrl_ff;
  pps_word_t   vcmd_ff;
  pps_word_t   uv_lim_ff;
  pps_word_t   ov_lim_ff;
  pps_word_t   oc_lim_ff;
  pps_word_t   ot_lim_ff;
  pps_word_t   pg_pct_ff;
  pps_word_t   delay_ms_ff;
  pps_word_t   ramp_ms_ff;
  pps_word_t   rdata_ff;
  logic [3:0]  fault_ff;
  logic        decoded_ff;
  logic [6:0]  addr_ff;
  logic        group_ff;
  logic [31:0] tmr_ff;
  logic        drv_ff;
  logic [15:0] target_ff;
  logic [15:0] start_ff;
  logic        above_ff;
  logic [8:0]  k_ff;
  logic [31:0] pg_cnt_ff;
  logic        pg_ff;
  logic        pg_pin_ff;
  logic [32:0] rem_ff;
  logic [31:0] quo_ff;
  logic [31:0] den_ff;
  logic [5:0]  div_cnt_ff;
  logic [15:0] peak_lim_ff;

  logic        operate;
  logic        decode_now;
  logic [15:0] uv_strap;
  logic [15:0] uv_wr_val;
  logic [31:0] delay_cyc;
  logic [31:0] step_len;
  logic        uv_ev;
  logic        ov_ev;
  logic        oc_ev;
  logic        ot_ev;
  logic        stop;
  logic        latched_any;
  logic        start_ok;
  logic        delay_done;
  logic        prebias_ov;
  logic        ramp_step;
  logic        ramp_end;
  logic [3:0]  fault_clr;
  logic [3:0]  fault_set;
  logic [15:0] diff;
  logic [24:0] interp;
  logic [8:0]  k_next;
  logic [23:0] v100;
  logic [23:0] win_lo;
  logic [23:0] win_hi;
  logic [6:0]  pct;
  logic        pg_cond;
  logic [31:0] div_num;
  logic [31:0] div_den;
  logic [33:0] div_trial;
  logic [47:0] ripple;

  assign operate = ctrl_ff[`PPS_CTRL_OPERATE];

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Lockout strap code to threshold in mV
  always_comb
  begin
    uv_strap = `PPS_UV_4V20;
    if (lockout_strap_code <= `PPS_LK_LOW_LAST)
      uv_strap = (lockout_strap_code == `PPS_LK_OPEN) ?
                 `PPS_UV_4V20 : `PPS_UV_4V50;
    else if (lockout_strap_code <= `PPS_LK_R51K1)
    begin
      unique case (lockout_strap_code)
        `PPS_LK_R26K1: uv_strap = `PPS_UV_4V20;
        `PPS_LK_R28K7: uv_strap = `PPS_UV_4V59;
        `PPS_LK_R31K6: uv_strap = `PPS_UV_5V06;
        `PPS_LK_R34K8: uv_strap = `PPS_UV_5V57;
        `PPS_LK_R38K3: uv_strap = `PPS_UV_6V13;
        `PPS_LK_R42K2: uv_strap = `PPS_UV_6V75;
        `PPS_LK_R46K4: uv_strap = `PPS_UV_7V42;
        default:       uv_strap = `PPS_UV_8V18;
      endcase
    end
    else if (lockout_strap_code <= `PPS_LK_HIGH_LAST)
      uv_strap = `PPS_UV_10V8;
  end

  // One decode after reset, held until next reset
  assign decode_now = strap_valid && !decoded_ff;

  // Address and setpoint group latch
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      decoded_ff <= 1'b0;
      addr_ff    <= 7'h00;
      group_ff   <= 1'b0;
    end
    else if (decode_now)
    begin
      decoded_ff <= 1'b1;
      if (address_strap_pin < `PPS_SA_GRP1_FIRST)
      begin
        addr_ff  <= `PPS_SA_BASE + {1'b0, address_strap_pin};
        group_ff <= 1'b0;
      end
      else if (address_strap_pin <= `PPS_SA_OPEN)
      begin
        addr_ff  <= `PPS_SA_BASE +
                    7'(address_strap_pin - `PPS_SA_GRP1_FIRST);
        group_ff <= 1'b1;
      end
      else
      begin
        addr_ff  <= `PPS_SA_BASE + 7'(`PPS_SA_OPEN - `PPS_SA_GRP1_FIRST);
        group_ff <= 1'b1;                                  // Unknown as open
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Host lockout writes are clamped to the legal range
  always_comb
  begin
    uv_wr_val = reg_wdata;
    if (reg_wdata < `PPS_UV_MIN)
      uv_wr_val = `PPS_UV_MIN;
    else if (reg_wdata > `PPS_UV_MAX)
      uv_wr_val = `PPS_UV_MAX;
  end

  // Lockout limit: strap at decode, host afterwards
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      uv_lim_ff <= `PPS_RST_UV_LIMIT;
    else if (decode_now)
      uv_lim_ff <= uv_strap;
    else if (reg_wr && reg_addr == `PPS_A_UV_LIMIT)
      uv_lim_ff <= uv_wr_val;
  end

  // Remaining host settings
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff     <= `PPS_RST_CTRL;
      vcmd_ff     <= `PPS_RST_VOUT_CMD;
      ov_lim_ff   <= `PPS_RST_OV_LIMIT;
      oc_lim_ff   <= `PPS_RST_OC_LIMIT;
      ot_lim_ff   <= `PPS_RST_OT_LIMIT;
      pg_pct_ff   <= `PPS_RST_PG_PCT;
      delay_ms_ff <= `PPS_RST_DELAY_MS;
      ramp_ms_ff  <= `PPS_RST_RAMP_MS;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `PPS_A_CTRL:      ctrl_ff     <= reg_wdata;
        `PPS_A_VOUT_CMD:  vcmd_ff     <= reg_wdata;
        `PPS_A_OV_LIMIT:  ov_lim_ff   <= reg_wdata;
        `PPS_A_OC_LIMIT:  oc_lim_ff   <= reg_wdata;
        `PPS_A_OT_LIMIT:  ot_lim_ff   <= reg_wdata;
        `PPS_A_PG_WINDOW: pg_pct_ff   <= reg_wdata;
        `PPS_A_DELAY_MS:  delay_ms_ff <= reg_wdata;
        `PPS_A_RAMP_MS:   ramp_ms_ff  <= reg_wdata;
        default:          ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peak current limit
  // ----------------------------------------------------------------
  // Ripple term is (vin - vout) * vout / (vin * fsw)
  assign div_num = (vin_mv > vcmd_ff) ?
                   (vin_mv - vcmd_ff) * vcmd_ff : 32'h0000_0000;
  assign div_den = vin_mv * fsw_khz;
  assign div_trial = {1'b0, rem_ff[31:0], quo_ff[31]} - {2'b00, den_ff};
  assign ripple = quo_ff * 48'(RIPPLE_GAIN);

  // Restoring divider, one quotient bit per cycle, runs forever
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem_ff      <= '0;
      quo_ff      <= 32'h0000_0000;
      den_ff      <= 32'h0000_0000;
      div_cnt_ff  <= 6'h00;
      peak_lim_ff <= `PPS_RST_OC_LIMIT;
    end
    else if (div_cnt_ff == 6'h00)
    begin
      if ({16'h0000, oc_lim_ff} + ripple > 48'h0000_0000_FFFF)
        peak_lim_ff <= 16'hFFFF;                            // Saturate
      else
        peak_lim_ff <= oc_lim_ff + ripple[15:0];
      rem_ff     <= '0;
      quo_ff     <= div_num;
      den_ff     <= div_den;
      div_cnt_ff <= 6'h20;
    end
    else
    begin
      if (!div_trial[33])
      begin
        rem_ff <= div_trial[32:0];
        quo_ff <= {quo_ff[30:0], 1'b1};
      end
      else
      begin
        rem_ff <= {rem_ff[31:0], quo_ff[31]};
        quo_ff <= {quo_ff[30:0], 1'b0};
      end
      div_cnt_ff <= div_cnt_ff - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection and flags
  // ----------------------------------------------------------------
  assign uv_ev = (st_ff != PPS_OFF) && (st_ff != PPS_RETRY) &&
                 (vin_mv < uv_lim_ff);
  assign ov_ev = drv_ff && (sense_positive > ov_lim_ff);
  assign oc_ev = drv_ff && ((iout_ma > oc_lim_ff) ||
                 (ipeak_ma > peak_lim_ff));
  assign ot_ev = $signed(temp_c) > $signed(ot_lim_ff);
  assign prebias_ov = delay_done && (sense_positive > ov_lim_ff);
  assign stop = uv_ev || ov_ev || ot_ev || !operate;
  assign latched_any = fault_ff[`PPS_F_UV] || fault_ff[`PPS_F_OV] ||
                       fault_ff[`PPS_F_OT];

  assign fault_clr = (reg_wr && reg_addr == `PPS_A_FAULT) ?
                     reg_wdata[3:0] : 4'h0;
  assign fault_set = {ot_ev, oc_ev, ov_ev || prebias_ov, uv_ev};

  // Sticky flags, set beats a same-cycle clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fault_ff <= 4'h0;
    else
      fault_ff <= (fault_ff & ~fault_clr) | fault_set;
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  assign delay_cyc = 32'(delay_ms_ff * CYC_PER_MS);
  assign step_len  = 32'((ramp_ms_ff * CYC_PER_MS) >> 8);
  assign start_ok  = operate && decoded_ff && !latched_any &&
                     (vin_mv >= uv_lim_ff);
  assign delay_done = (st_ff == PPS_DELAY) && (tmr_ff >= delay_cyc);
  assign ramp_step = (st_ff == PPS_RAMP) &&
                     (tmr_ff + 32'h0000_0001 >= step_len) &&
                     (k_ff != `PPS_RAMP_STEPS);
  assign ramp_end  = (st_ff == PPS_RAMP) && (k_ff == `PPS_RAMP_STEPS);

  // State, shared timer and driver enable
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff  <= PPS_OFF;
      tmr_ff <= 32'h0000_0000;
      drv_ff <= 1'b0;
    end
    else
    begin
      tmr_ff <= tmr_ff + 32'h0000_0001;
      unique case (st_ff)
        PPS_OFF:
        begin
          tmr_ff <= 32'h0000_0000;
          if (start_ok)
            st_ff <= PPS_DELAY;
        end
        PPS_DELAY:
        begin
          if (stop || prebias_ov)
            st_ff <= PPS_OFF;
          else if (delay_done)
          begin
            st_ff  <= PPS_RAMP;
            tmr_ff <= 32'h0000_0000;
            drv_ff <= 1'b1;
          end
        end
        PPS_RAMP, PPS_ON:
        begin
          if (ramp_step)
            tmr_ff <= 32'h0000_0000;
          if (stop)
          begin
            st_ff  <= PPS_OFF;
            drv_ff <= 1'b0;
          end
          else if (oc_ev)
          begin
            st_ff  <= PPS_RETRY;
            tmr_ff <= 32'h0000_0000;
            drv_ff <= 1'b0;
          end
          else if (ramp_end)
            st_ff <= PPS_ON;
        end
        PPS_RETRY:
        begin
          if (!operate || latched_any)
            st_ff <= PPS_OFF;
          else if (tmr_ff >= OC_RETRY_CYC - 1)
          begin
            st_ff  <= PPS_DELAY;
            tmr_ff <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working target
  // ----------------------------------------------------------------
  assign k_next = k_ff + 9'h001;
  assign diff   = vcmd_ff - start_ff;
  assign interp = diff * k_next;

  // Prebias capture and linear ramp in 256 equal steps
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      target_ff <= 16'h0000;
      start_ff  <= 16'h0000;
      above_ff  <= 1'b0;
      k_ff      <= 9'h000;
    end
    else if (st_ff == PPS_DELAY && delay_done && !stop && !prebias_ov)
    begin
      start_ff  <= sense_positive;
      target_ff <= sense_positive;
      above_ff  <= sense_positive >= vcmd_ff;
      k_ff      <= 9'h000;
    end
    else if (ramp_step)
    begin
      k_ff <= k_next;
      if (!above_ff)
        target_ff <= start_ff + interp[23:8];
    end
    else if (ramp_end || st_ff == PPS_ON)
      target_ff <= vcmd_ff;
    else if (st_ff == PPS_OFF || st_ff == PPS_RETRY)
      target_ff <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Power good
  // ----------------------------------------------------------------
  assign pct    = (pg_pct_ff > 16'h0064) ? 7'h64 : pg_pct_ff[6:0];
  assign v100   = sense_positive * 8'h64;
  assign win_lo = vcmd_ff * (8'h64 - {1'b0, pct});
  assign win_hi = vcmd_ff * (8'h64 + {1'b0, pct});
  assign pg_cond = (st_ff == PPS_ON) && !stop && !oc_ev &&
                   (v100 >= win_lo) && (v100 <= win_hi);

  // Conditions must hold unbroken for the full delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_cnt_ff <= 32'h0000_0000;
      pg_ff     <= 1'b0;
    end
    else if (!pg_cond)
    begin
      pg_cnt_ff <= 32'h0000_0000;
      pg_ff     <= 1'b0;
    end
    else if (pg_cnt_ff >= PG_DELAY_CYC - 1)
      pg_ff <= 1'b1;
    else
      pg_cnt_ff <= pg_cnt_ff + 32'h0000_0001;
  end

  // Pin level with programmable polarity
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pg_pin_ff <= 1'b0;
    else
      pg_pin_ff <= ctrl_ff[`PPS_CTRL_PG_HIGH] ? pg_ff : !pg_ff;
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `PPS_A_CTRL:       rdata_ff <= ctrl_ff;
        `PPS_A_STATUS:     rdata_ff <= {1'b0, addr_ff, 1'b0, st_ff,
                                        decoded_ff, group_ff, pg_ff, drv_ff};
        `PPS_A_FAULT:      rdata_ff <= {12'h000, fault_ff};
        `PPS_A_VOUT_CMD:   rdata_ff <= vcmd_ff;
        `PPS_A_UV_LIMIT:   rdata_ff <= uv_lim_ff;
        `PPS_A_OV_LIMIT:   rdata_ff <= ov_lim_ff;
        `PPS_A_OC_LIMIT:   rdata_ff <= oc_lim_ff;
        `PPS_A_OT_LIMIT:   rdata_ff <= ot_lim_ff;
        `PPS_A_PG_WINDOW:  rdata_ff <= pg_pct_ff;
        `PPS_A_DELAY_MS:   rdata_ff <= delay_ms_ff;
        `PPS_A_RAMP_MS:    rdata_ff <= ramp_ms_ff;
        `PPS_A_PEAK_LIMIT: rdata_ff <= peak_lim_ff;
        `PPS_A_TARGET:     rdata_ff <= target_ff;
        default:           rdata_ff <= 16'h0000;            // Unmapped
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata             = rdata_ff;
  assign drivers_enable        = drv_ff;
  assign target_mv             = target_ff;
  assign power_good_output     = pg_pin_ff;
  assign bus_address           = addr_ff;
  assign setpoint_group_select = group_ff;

endmodule

//--- hw/pps_map.svh
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPS_CLK_MHZ        200
`define PPS_CYC_PER_MS     (`PPS_CLK_MHZ * 1000)
`define PPS_OC_RETRY_MS    70
`define PPS_OC_RETRY_CYC   (`PPS_OC_RETRY_MS * `PPS_CYC_PER_MS)
`define PPS_PG_DELAY_MS    4
`define PPS_PG_DELAY_CYC   (`PPS_PG_DELAY_MS * `PPS_CYC_PER_MS)
`define PPS_RAMP_STEPS     9'h100

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define PPS_A_CTRL         8'h00
`define PPS_A_STATUS       8'h01
`define PPS_A_FAULT        8'h02
`define PPS_A_VOUT_CMD     8'h03
`define PPS_A_UV_LIMIT     8'h04
`define PPS_A_OV_LIMIT     8'h05
`define PPS_A_OC_LIMIT     8'h06
`define PPS_A_OT_LIMIT     8'h07
`define PPS_A_PG_WINDOW    8'h08
`define PPS_A_DELAY_MS     8'h09
`define PPS_A_RAMP_MS      8'h0A
`define PPS_A_PEAK_LIMIT   8'h0B
`define PPS_A_TARGET       8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPS_CTRL_OPERATE   0
`define PPS_CTRL_PG_HIGH   1
`define PPS_F_UV           0
`define PPS_F_OV           1
`define PPS_F_OC           2
`define PPS_F_OT           3

// ----------------------------------------------------------------
// Reset values (mV, mA, degC, percent, ms)
// ----------------------------------------------------------------
`define PPS_RST_CTRL       16'h0002
`define PPS_RST_VOUT_CMD   16'h04B0
`define PPS_RST_OV_LIMIT   16'h0564
`define PPS_RST_UV_LIMIT   16'h1068
`define PPS_RST_OC_LIMIT   16'h61A8
`define PPS_RST_OT_LIMIT   16'h0073
`define PPS_RST_PG_PCT     16'h000A
`define PPS_RST_DELAY_MS   16'h0005
`define PPS_RST_RAMP_MS    16'h0005
`define PPS_UV_MIN         16'h1054
`define PPS_UV_MAX         16'h3E80

// ----------------------------------------------------------------
// Lockout strap codes and thresholds (mV)
// ----------------------------------------------------------------
`define PPS_LK_OPEN        5'h00
`define PPS_LK_LOW_LAST    5'h0A
`define PPS_LK_R26K1       5'h0B
`define PPS_LK_R28K7       5'h0C
`define PPS_LK_R31K6       5'h0D
`define PPS_LK_R34K8       5'h0E
`define PPS_LK_R38K3       5'h0F
`define PPS_LK_R42K2       5'h10
`define PPS_LK_R46K4       5'h11
`define PPS_LK_R51K1       5'h12
`define PPS_LK_HIGH_LAST   5'h1A
`define PPS_UV_4V20        16'h1068
`define PPS_UV_4V50        16'h1194
`define PPS_UV_4V59        16'h11EE
`define PPS_UV_5V06        16'h13C4
`define PPS_UV_5V57        16'h15C2
`define PPS_UV_6V13        16'h17F2
`define PPS_UV_6V75        16'h1A5E
`define PPS_UV_7V42        16'h1CFC
`define PPS_UV_8V18        16'h1FF4
`define PPS_UV_10V8        16'h2A30

// ----------------------------------------------------------------
// Address strap codes
// ----------------------------------------------------------------
`define PPS_SA_GRP1_FIRST  6'h11
`define PPS_SA_OPEN        6'h20
`define PPS_SA_BASE        7'h19

`endif

//--- hw/pps_pkg.sv
package pps_pkg;

  // Register data word
  typedef logic [15:0] pps_word_t;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    PPS_OFF,
    PPS_DELAY,
    PPS_RAMP,
    PPS_ON,
    PPS_RETRY
  } pps_state_t;

endpackage

//--- tb/pps_manager_sva.sv
`timescale 1ns/1ps
module pps_manager_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [15:0] vin_mv,
  input wire logic [15:0] sense_positive,
  input wire logic [15:0] iout_ma,
  input wire logic [15:0] temp_c,
  input wire logic        drivers_enable,
  input wire logic [15:0] target_mv,
  input wire logic        power_good_output,
  input wire logic [6:0]  bus_address,
  input wire logic        setpoint_group_select
);
  // Cycles spent on the 1200 mV setpoint inside the 10% window
  logic [3:0] settle_ff;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      settle_ff <= 4'h0;
    else if (!drivers_enable || target_mv != 16'h04B0 ||
             sense_positive < 16'h0438 || sense_positive > 16'h0528)
      settle_ff <= 4'h0;
    else if (settle_ff != 4'hF)
      settle_ff <= settle_ff + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Faults drop the drivers on the next edge
  a_uv_cutoff:
    assert property (drivers_enable && vin_mv < 16'h1054 |=> !drivers_enable)
    else $error("lockout cutoff late");
  a_ov_cutoff:
    assert property (drivers_enable && sense_positive > 16'h0564
      |=> !drivers_enable) else $error("overvoltage cutoff late");
  a_ot_cutoff:
    assert property (drivers_enable && $signed(temp_c) > 16'sh0073
      |=> !drivers_enable) else $error("overheat cutoff late");
  a_oc_retry:
    assert property (drivers_enable && iout_ma > 16'h61A8
      |=> !drivers_enable ##[90:200] $rose(drivers_enable))
    else $error("overcurrent retry wrong");
  // Start and ramp from the sampled bias
  a_prebias_start:
    assert property ($rose(drivers_enable)
      |-> target_mv == $past(sense_positive)) else $error("bad start");
  a_ramp_time:
    assert property ($rose(drivers_enable) && $past(sense_positive) < 16'h04B0
      |-> ##[240:270] target_mv == 16'h04B0) else $error("ramp length");
  a_pg_settle:
    assert property ($rose(power_good_output) |-> settle_ff >= 4'h9)
    else $error("power good early");
  a_strap_held:
    assert property (bus_address != 7'h00 |=> $stable(bus_address)
      && $stable(setpoint_group_select)) else $error("strap changed");
  c_pg: cover property ($rose(power_good_output));
  c_oc: cover property (drivers_enable && iout_ma > 16'h61A8);
  c_high: cover property ($rose(drivers_enable) && target_mv > 16'h04B0);
endmodule

bind pps_manager pps_manager_sva i_pps_manager_sva (.*);

//--- tb/pps_stage_model.sv
`timescale 1ns/1ps
module pps_stage_model (
  input  wire logic        drivers_enable,
  input  wire logic [15:0] target_mv,
  input  wire logic [15:0] prebias_mv,
  input  wire logic [15:0] bump_mv,
  output logic      [15:0] sense_positive
);
  // Output tracks the setpoint while switching, else the outside bias
  assign sense_positive = drivers_enable ? target_mv + bump_mv : prebias_mv;
endmodule

//--- tb/pps_manager_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pps_manager_tb;
  import pps_pkg::*;
  logic        clock, rst_n, reg_wr, reg_rd, strap_valid, drivers_enable;
  logic        power_good_output, setpoint_group_select;
  logic [7:0]  reg_addr;
  logic [4:0]  lockout_strap_code;
  logic [5:0]  address_strap_pin;
  logic [6:0]  bus_address;
  logic [15:0] vin_mv, sense_positive, iout_ma, ipeak_ma, temp_c, fsw_khz;
  logic [15:0] target_mv, prebias_mv, bump_mv;
  pps_word_t   reg_wdata, reg_rdata, d, tgt;
  int          miscompares = 0;
  int          tests_run = 0;
  logic [4:0]  lkc [5] = '{5'h00, 5'h01, 5'h0B, 5'h0C, 5'h13};
  logic [5:0]  sap [5] = '{6'h00, 6'h10, 6'h11, 6'h1E, 6'h20};
  logic [6:0]  adr [5] = '{7'h19, 7'h29, 7'h19, 7'h26, 7'h28};
  pps_word_t   uvt [5] = '{16'h1068, 16'h1194, 16'h1068, 16'h11EE, 16'h2A30};
  pps_word_t   ra [4] = '{16'h0005, 16'h0007, 16'h0006, 16'h0020};
  pps_word_t   rv [4] = '{16'h0564, 16'h0073, 16'h61A8, 16'h0000};

  pps_manager #(.CYC_PER_MS(16), .OC_RETRY_CYC(40), .PG_DELAY_CYC(8))
    i_pps_manager (.*);
  pps_stage_model i_pps_stage_model (.*);

  // Clock at 5 ns
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic wr(input logic [7:0] a, input pps_word_t v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Wait up to n cycles for drivers or power good to reach v
  task automatic hold(input bit pg, input logic v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      #1;
      if ((pg ? power_good_output : drivers_enable) === v) break;
    end
    `CHK("level", v, (pg ? power_good_output : drivers_enable))
    tgt = target_mv;
    @(posedge clock);
  endtask

  // Latched fault blocks restart until cleared, then full start-up
  task automatic trip(input pps_word_t f);
    repeat (300) @(posedge clock);
    #1 `CHK("drv", 1'b0, drivers_enable)
    rd(8'h02);
    `CHK("fault", f, d)
    wr(8'h02, f);
    hold(0, 1'b1, 200);
    hold(1, 1'b1, 600);
    `CHK("target", 16'h04B0, target_mv)
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end

  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, iout_ma, ipeak_ma, bump_mv} = '0;
    {rst_n, strap_valid} = '0;
    vin_mv = 16'h2EE0;
    temp_c = 16'h0019;
    fsw_khz = 16'h01F4;
    prebias_mv = 16'h01F4;
    foreach (lkc[i])
    begin
      rst_n <= 1'b0;
      strap_valid <= 1'b0;
      lockout_strap_code <= lkc[i];
      address_strap_pin <= sap[i];
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      strap_valid <= 1'b1;
      rd(8'h04);
      `CHK("lockout", uvt[i], d)
      `CHK("addr", adr[i], bus_address)
      `CHK("group", (i > 1), setpoint_group_select)
    end
    address_strap_pin <= 6'h00;
    rd(8'h04);
    `CHK("held", 7'h28, bus_address)
    foreach (ra[i])
    begin
      rd(ra[i][7:0]);
      `CHK("reg", rv[i], d)
    end
    wr(8'h04, 16'h0FA0);
    rd(8'h04);
    `CHK("input_lockout", 16'h1054, d)
    wr(8'h04, 16'h4E20);
    rd(8'h04);
    `CHK("uvhi", 16'h3E80, d)
    wr(8'h04, 16'h1194);
    wr(8'h00, 16'h0003);
    hold(0, 1'b1, 200);
    `CHK("start", 16'h01F4, tgt)
    hold(1, 1'b1, 600);
    iout_ma <= 16'h7530;
    hold(0, 1'b0, 5);
    iout_ma <= 16'h03E8;
    rd(8'h02);
    `CHK("oc", 16'h0004, d)
    wr(8'h02, 16'h0004);
    hold(0, 1'b1, 300);
    hold(1, 1'b1, 600);
    temp_c <= 16'h0078;
    hold(0, 1'b0, 5);
    temp_c <= 16'h0019;
    trip(16'h0008);
    vin_mv <= 16'h0BB8;
    hold(0, 1'b0, 5);
    vin_mv <= 16'h2EE0;
    trip(16'h0001);
    bump_mv <= 16'h0190;
    hold(0, 1'b0, 5);
    bump_mv <= 16'h0000;
    prebias_mv <= 16'h05DC;
    wr(8'h02, 16'h0002);
    repeat (150) @(posedge clock);
    prebias_mv <= 16'h0514;
    trip(16'h0002);
    rd(8'h0B);
    `CHK("peak", 16'h61AA, d)
    wr(8'h00, 16'h0001);
    hold(1, 1'b0, 5);
    rd(8'h01);
    `CHK("status", 2'b11, d[1:0])
    conclude();
  end
endmodule
